// file: rtl/srw_pkg.sv
// shared constants, types and helpers for the serial block write receiver
package srw_pkg;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam logic [7:0] BLOCK_MAX = 8'h80;
	localparam logic [7:0] ID_FIRST = 8'h00;
	localparam logic [7:0] ID_CONT = 8'hFF;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] CODE_WRITE = 8'h41;
	localparam logic [7:0] AREA_BLOCK = 8'h44;
	localparam logic [7:0] DLE_BYTE = 8'h10;
	localparam logic [7:0] ETX_BYTE = 8'h03;
	localparam logic [7:0] BCC_INIT = 8'h00;
	// header byte positions, counted from zero
	localparam logic [3:0] POS_ID = 4'h0;
	localparam logic [3:0] POS_ZERO = 4'h1;
	localparam logic [3:0] POS_CODE = 4'h2;
	localparam logic [3:0] POS_AREA = 4'h3;
	localparam logic [3:0] POS_BLK_NUM = 4'h4;
	localparam logic [3:0] POS_WORD_NUM = 4'h5;
	localparam logic [3:0] POS_LEN_HI = 4'h6;
	localparam logic [3:0] POS_LEN_LO = 4'h7;
	localparam logic [3:0] HDR_LAST_FIRST = 4'h9;
	localparam logic [3:0] HDR_LAST_CONT = 4'h3;
	// response byte positions
	localparam logic [2:0] TX_IDX_ID = 3'h0;
	localparam logic [2:0] TX_IDX_ERR = 3'h3;
	localparam logic [2:0] TX_IDX_DLE = 3'h4;
	localparam logic [2:0] TX_IDX_ETX = 3'h5;
	localparam logic [2:0] TX_IDX_BCC = 3'h6;
	// error numbers, values arbitrary
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_HDR = 8'h01;
	localparam logic [7:0] ERR_LEN = 8'h02;
	localparam logic [7:0] ERR_SEQ = 8'h03;

	typedef enum logic [2:0] {S_HDR, S_DATA, S_DRAIN, S_WAIT} srw_st_t;
	typedef enum logic {T_IDLE, T_SEND} srw_tx_st_t;

	function automatic logic [7:0] bcc_step(input logic [7:0] acc, input logic [7:0] b);
		bcc_step = acc ^ b;
	endfunction : bcc_step
endpackage : srw_pkg

// file: rtl/srw_fifo.sv
// data fifo with registered output stage
`timescale 1ns/1ns
`default_nettype none
module srw_fifo import srw_pkg::*; #(
	parameter int unsigned W = DATA_W,
	parameter int unsigned DEPTH = FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready,
	output logic [$clog2(DEPTH+1)-1:0] count,
	output logic idle
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH+1);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] cnt;
		logic [W-1:0] od;
		logic ov;
	} srw_fifo_st_t;
	srw_fifo_st_t q, d;
	logic push, pop;

	assign in_ready = q.cnt != CW'(DEPTH);
	assign out_valid = q.ov;
	assign out_data = q.od;
	assign count = q.cnt;
	assign idle = (q.cnt == '0) && !q.ov;

	always_comb begin
		d = q;
		push = in_valid && in_ready;
		pop = (q.cnt != '0) && (!q.ov || out_ready);
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp = AW'((q.wp + 1'b1) % DEPTH);
		end
		if (pop) begin
			d.od = q.mem[q.rp];
			d.ov = 1'b1;
			d.rp = AW'((q.rp + 1'b1) % DEPTH);
		end else if (out_ready) begin
			d.ov = 1'b0;
		end
		d.cnt = CW'(q.cnt + CW'(push) - CW'(pop));
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	fifo_bound_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.cnt <= CW'(DEPTH) && (q.cnt != CW'(DEPTH) || !in_ready)) else $error("fifo accepts while full");
endmodule : srw_fifo
`default_nettype wire

// file: rtl/srw_resp_tx.sv
// response frame sender
`timescale 1ns/1ns
`default_nettype none
module srw_resp_tx import srw_pkg::*; (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic cont,
	input wire logic [7:0] err_num,
	input wire logic bcc_en,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic busy
);
	typedef struct packed {
		srw_tx_st_t st;
		logic [2:0] idx;
		logic cont;
		logic bcc_en;
		logic [7:0] err;
		logic [7:0] bcc;
		logic [7:0] data;
		logic valid;
	} srw_tx_q_t;
	srw_tx_q_t q, d;
	logic [2:0] nidx;
	logic [2:0] last;

	function automatic logic [7:0] resp_byte(input logic [2:0] i, input logic c, input logic [7:0] e,
		input logic [7:0] b);
		if (i == TX_IDX_ID) begin
			resp_byte = c ? ID_CONT : ID_FIRST;
		end else if (i == TX_IDX_ERR) begin
			resp_byte = e;
		end else if (i == TX_IDX_DLE) begin
			resp_byte = DLE_BYTE;
		end else if (i == TX_IDX_ETX) begin
			resp_byte = ETX_BYTE;
		end else if (i == TX_IDX_BCC) begin
			resp_byte = b;
		end else begin
			resp_byte = ZERO_BYTE;
		end
	endfunction : resp_byte

	assign tx_data = q.data;
	assign tx_valid = q.valid;
	assign busy = q.st == T_SEND;

	always_comb begin
		d = q;
		nidx = 3'(q.idx + 3'h1);
		last = q.bcc_en ? TX_IDX_BCC : TX_IDX_ETX;
		case (q.st)
			T_IDLE: begin
				if (start) begin
					d.st = T_SEND;
					d.idx = TX_IDX_ID;
					d.cont = cont;
					d.err = err_num;
					d.bcc_en = bcc_en;
					d.valid = 1'b1;
					d.data = resp_byte(TX_IDX_ID, cont, err_num, BCC_INIT);
					d.bcc = bcc_step(BCC_INIT, d.data);
				end
			end
			T_SEND: begin
				if (q.valid && tx_ready) begin
					if (q.idx == last) begin
						d.st = T_IDLE;
						d.valid = 1'b0;
					end else begin
						d.idx = nidx;
						d.data = resp_byte(nidx, q.cont, q.err, q.bcc);
						if (nidx != TX_IDX_BCC) begin
							d.bcc = bcc_step(q.bcc, d.data);
						end
					end
				end
			end
			default: d.st = T_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	resp_id_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		start && !busy |=> tx_valid && tx_data == ($past(cont) ? ID_CONT : ID_FIRST))
		else $error("response id byte wrong");
	err_byte_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		busy && q.idx == TX_IDX_ERR |-> tx_data == q.err) else $error("error number not in fourth byte");
	bcc_option_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		busy && tx_ready && q.idx == TX_IDX_ETX && !q.bcc_en |=> !busy) else $error("block check sent while off");
endmodule : srw_resp_tx
`default_nettype wire

// file: rtl/srw_frame_rx.sv
// write frame receiver: header check, data delivery, response
`timescale 1ns/1ns
`default_nettype none
module srw_frame_rx import srw_pkg::*; (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic bcc_en,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic rx_end,
	input wire logic [7:0] rx_bcc,
	input wire logic rx_link_err,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] host_data,
	output logic host_valid,
	input wire logic host_ready,
	output logic [7:0] data_block_number,
	output logic [7:0] data_word_number,
	output logic [7:0] resp_err,
	output logic link_err
);
	typedef struct packed {
		srw_st_t st;
		logic [3:0] idx;
		logic cont;
		logic hdr_err;
		logic seq_err;
		logic over;
		logic pend;
		logic [7:0] pay_cnt;
		logic [7:0] bcc;
		logic [15:0] len;
		logic [15:0] remain;
		logic [7:0] blk_num;
		logic [7:0] word_num;
		logic [7:0] err;
		logic rx_ready;
		logic tx_start;
		logic link_err;
	} srw_rx_q_t;
	srw_rx_q_t q, d;
	logic acc;
	logic push;
	logic end_now;
	logic bcc_ok;
	logic len_bad;
	logic [3:0] hdr_last;
	logic [15:0] exp_len;
	logic [7:0] want;
	logic fifo_ready;
	logic fifo_idle;
	logic [3:0] fifo_cnt;
	logic tx_busy;

	function automatic logic [7:0] pick_err(input logic s, input logic h, input logic l);
		if (s) begin
			pick_err = ERR_SEQ;
		end else if (h) begin
			pick_err = ERR_HDR;
		end else if (l) begin
			pick_err = ERR_LEN;
		end else begin
			pick_err = ERR_NONE;
		end
	endfunction : pick_err

	assign rx_ready = q.rx_ready;
	assign data_block_number = q.blk_num;
	assign data_word_number = q.word_num;
	assign resp_err = q.err;
	assign link_err = q.link_err;

	always_comb begin
		d = q;
		d.tx_start = 1'b0;
		d.link_err = 1'b0;
		acc = rx_valid && q.rx_ready;
		push = 1'b0;
		end_now = 1'b0;
		bcc_ok = 1'b1;
		len_bad = 1'b0;
		exp_len = '0;
		want = '0;
		hdr_last = q.cont ? HDR_LAST_CONT : HDR_LAST_FIRST;
		case (q.st)
			S_HDR: begin
				if (rx_link_err) begin
					d.idx = POS_ID;
					d.link_err = 1'b1;
				end else if (acc) begin
					d.bcc = bcc_step(q.bcc, rx_data);
					d.idx = 4'(q.idx + 4'h1);
					if (q.idx == POS_ID) begin
						d.bcc = bcc_step(BCC_INIT, rx_data);
						d.cont = rx_data == ID_CONT;
						d.hdr_err = (rx_data != ID_CONT) && (rx_data != ID_FIRST);
						d.seq_err = (rx_data == ID_CONT) && !q.pend;
						d.pay_cnt = '0;
						d.over = 1'b0;
					end else if (q.idx == POS_ZERO) begin
						d.hdr_err = q.hdr_err || (rx_data != ZERO_BYTE);
					end else if (q.idx == POS_CODE) begin
						d.hdr_err = q.hdr_err || (rx_data != CODE_WRITE);
					end else if (q.idx == POS_AREA) begin
						d.hdr_err = q.hdr_err || (rx_data != AREA_BLOCK);
					end else if (q.idx == POS_BLK_NUM) begin
						d.blk_num = rx_data;
					end else if (q.idx == POS_WORD_NUM) begin
						d.word_num = rx_data;
					end else if (q.idx == POS_LEN_HI) begin
						d.len[15:8] = rx_data;
					end else if (q.idx == POS_LEN_LO) begin
						d.len[7:0] = rx_data;
					end
					if (q.idx != POS_ID && q.idx == hdr_last) begin
						d.st = S_DATA;
					end
				end else if (rx_end && q.idx != POS_ID) begin
					d.hdr_err = 1'b1;
					end_now = 1'b1;
				end
			end
			S_DATA: begin
				if (rx_link_err) begin
					d.st = S_HDR;
					d.idx = POS_ID;
					d.link_err = 1'b1;
				end else if (acc) begin
					d.bcc = bcc_step(q.bcc, rx_data);
					if (q.pay_cnt < BLOCK_MAX) begin
						d.pay_cnt = 8'(q.pay_cnt + 8'h01);
						push = !q.hdr_err && !q.seq_err;
					end else begin
						d.over = 1'b1;
					end
				end else if (rx_end) begin
					end_now = 1'b1;
				end
			end
			S_DRAIN: begin
				if (fifo_idle) begin
					d.tx_start = 1'b1;
					d.st = S_WAIT;
				end
			end
			S_WAIT: begin
				if (!q.tx_start && !tx_busy) begin
					d.st = S_HDR;
					d.idx = POS_ID;
				end
			end
			default: d.st = S_HDR;
		endcase
		if (end_now) begin
			bcc_ok = !bcc_en || (bcc_step(bcc_step(q.bcc, DLE_BYTE), ETX_BYTE) == rx_bcc);
			exp_len = q.cont ? q.remain : q.len;
			want = (exp_len > {8'h00, BLOCK_MAX}) ? BLOCK_MAX : exp_len[7:0];
			len_bad = q.over || (q.pay_cnt != want);
			if (!bcc_ok) begin
				d.st = S_HDR;
				d.idx = POS_ID;
				d.link_err = 1'b1;
			end else begin
				d.st = S_DRAIN;
				d.err = pick_err(d.seq_err, d.hdr_err, len_bad);
				if (d.err != ERR_NONE) begin
					d.pend = 1'b0;
					d.remain = '0;
				end else begin
					d.remain = 16'(exp_len - {8'h00, q.pay_cnt});
					d.pend = d.remain != '0;
				end
			end
		end
		d.rx_ready = ((d.st == S_HDR) || (d.st == S_DATA)) && ((5'(fifo_cnt) + 5'(push)) < 5'(FIFO_DEPTH));
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	srw_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.in_valid(push),
		.in_data(rx_data),
		.in_ready(fifo_ready),
		.out_valid(host_valid),
		.out_data(host_data),
		.out_ready(host_ready),
		.count(fifo_cnt),
		.idle(fifo_idle)
	);

	srw_resp_tx u_tx (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(q.tx_start),
		.cont(q.cont),
		.err_num(q.err),
		.bcc_en(bcc_en),
		.tx_data(tx_data),
		.tx_valid(tx_valid),
		.tx_ready(tx_ready),
		.busy(tx_busy)
	);

	resp_after_data_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.tx_start |-> fifo_idle && tx_busy == 1'b0) else $error("response before data delivered");
	push_room_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		push |-> fifo_ready) else $error("push into full fifo");
	bad_hdr_drop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		push |-> !q.hdr_err && !q.seq_err) else $error("data of bad header delivered");
	hdr_err_num_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.tx_start && (q.hdr_err || q.seq_err) |-> q.err != ERR_NONE) else $error("error frame answered with zero");
	block_cap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		push |-> q.pay_cnt < BLOCK_MAX) else $error("more than one block delivered");
	cont_header_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.st == S_HDR && acc && q.cont && q.idx == HDR_LAST_CONT && !rx_link_err |=> q.st == S_DATA)
		else $error("continuation header not four bytes");
	link_err_quiet_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.st == S_DATA && rx_link_err |=> q.st == S_HDR && !q.tx_start ##1 !q.tx_start)
		else $error("link error answered by response");
	resp_done_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.tx_start |=> tx_valid ##[1:700] q.st == S_HDR) else $error("response did not finish");

	// stream and hand-off checks
	rx_hold_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.st == S_DRAIN || q.st == S_WAIT |-> !rx_ready)
		else $error("byte accepted while answering");
	end_stops_rx_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.st == S_DATA && rx_end && !acc && !rx_link_err |=> !rx_ready || link_err)
		else $error("stream open after frame end");
	host_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		host_valid && !host_ready |=> host_valid && $stable(host_data))
		else $error("host byte dropped before taken");
	tx_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("response byte dropped before taken");
	payload_only_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		push |-> q.st == S_DATA)
		else $error("header byte delivered to host");
	drain_wait_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.st == S_DRAIN && !fifo_idle |=> q.st == S_DRAIN && !q.tx_start)
		else $error("response started before host drained");

	// header and length checks
	first_header_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.st == S_HDR && acc && !q.cont && q.idx == HDR_LAST_FIRST && !rx_link_err |=> q.st == S_DATA)
		else $error("first header not ten bytes");
	hdr_short_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.st == S_HDR && !acc && !rx_link_err && rx_end && q.idx != POS_ID |=> q.hdr_err)
		else $error("short header not flagged");
	over_no_push_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.st == S_DATA && acc && !rx_link_err && q.pay_cnt == BLOCK_MAX |-> !push ##1 q.over)
		else $error("byte past block limit delivered");
	addr_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.st == S_DATA |=> $stable(data_block_number) && $stable(data_word_number))
		else $error("block address changed in payload");

	// judging and response checks
	seq_err_code_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.tx_start && q.seq_err |-> q.err == ERR_SEQ)
		else $error("sequence error number wrong");
	len_err_code_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.tx_start && q.over && !q.seq_err && !q.hdr_err |-> q.err == ERR_LEN)
		else $error("overlong frame not flagged");
	err_clears_pend_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.tx_start && q.err != ERR_NONE |-> !q.pend)
		else $error("continuation kept after error");
	cont_resp_id_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.tx_start && q.cont |=> tx_data == ID_CONT)
		else $error("continuation answered with plain id");
	resp_once_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		q.tx_start |=> !q.tx_start)
		else $error("response started twice");

	// link fault checks
	link_no_resp_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		link_err |-> q.st == S_HDR && !q.tx_start)
		else $error("link fault led to response");
	bcc_bad_drop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		end_now && !bcc_ok |=> link_err && !q.tx_start)
		else $error("bad block check answered");
endmodule : srw_frame_rx
`default_nettype wire

// file: sim/srw_partner.sv
// active link partner: sends write frames, takes response bytes
`timescale 1ns/1ns
`default_nettype none
module srw_partner import srw_pkg::*; (
	input wire logic core_clk,
	input wire logic bcc_en,
	output var logic [7:0] rx_data,
	output var logic rx_valid,
	input wire logic rx_ready,
	output var logic rx_end,
	output var logic [7:0] rx_bcc,
	output var logic rx_link_err,
	output var logic tx_ready
);
	logic [7:0] last;
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		rx_end = 1'b0;
		rx_bcc = 8'h00;
		rx_link_err = 1'b0;
		last = 8'h00;
	end
	// response consumer stalls at random
	always @(negedge core_clk) tx_ready <= ($urandom_range(3) != 0);
	// one frame, bytes held until taken, then end mark or link fault
	task automatic send_frame(input logic [7:0] fr[$], input logic bad, input logic lerr);
		logic [7:0] x;
		int n;
		x = BCC_INIT;
		foreach (fr[i]) begin
			n = 0;
			@(negedge core_clk);
			rx_data <= fr[i];
			rx_valid <= 1'b1;
			x = x ^ fr[i];
			last = fr[i];
			while (rx_ready !== 1'b1 && n < 500) begin
				@(negedge core_clk);
				n++;
			end
			@(posedge core_clk);
		end
		@(negedge core_clk);
		rx_valid <= 1'b0;
		rx_data <= ~last;
		if (lerr) begin
			rx_link_err <= 1'b1;
		end else begin
			rx_end <= 1'b1;
			rx_bcc <= (bcc_en ? (x ^ DLE_BYTE ^ ETX_BYTE) : ~x) ^ {8{bad}};
		end
		@(negedge core_clk);
		rx_end <= 1'b0;
		rx_link_err <= 1'b0;
		rx_bcc <= ~rx_bcc;
	endtask : send_frame
endmodule : srw_partner
`default_nettype wire

// file: sim/srw_frame_rx_tb.sv
// self-checking bench for the write frame receiver
`timescale 1ns/1ns
`default_nettype none
module srw_frame_rx_tb import srw_pkg::*; ();
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic bcc_en = 1'b0;
	logic host_ready = 1'b0;
	logic slow = 1'b0;
	logic [7:0] rx_data, rx_bcc, tx_data, host_data, dbn, dwn, resp_err;
	logic rx_valid, rx_ready, rx_end, rx_link_err, tx_valid, tx_ready, host_valid, link_err;
	logic [7:0] qt[$], qh[$], f[$];
	int n_fail = 0;
	int tests_run = 0;
	int n_link = 0;
	always #5 core_clk = ~core_clk;
	srw_frame_rx u_srw_frame_rx (.core_clk(core_clk), .sys_rst(sys_rst), .bcc_en(bcc_en), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_end(rx_end), .rx_bcc(rx_bcc), .rx_link_err(rx_link_err),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .host_data(host_data),
		.host_valid(host_valid), .host_ready(host_ready), .data_block_number(dbn),
		.data_word_number(dwn), .resp_err(resp_err), .link_err(link_err));
	srw_partner u_srw_partner (.core_clk(core_clk), .bcc_en(bcc_en), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_end(rx_end), .rx_bcc(rx_bcc), .rx_link_err(rx_link_err), .tx_ready(tx_ready));
	task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
		tests_run++;
		if (s !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
			n_fail++;
		end
	endtask : cmp
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	always @(negedge core_clk) host_ready <= slow ? ($urandom_range(7) == 0) : ($urandom_range(1) == 1);
	always @(posedge core_clk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) cmp("tx_data", qt.size() ? qt.pop_front() : 8'hXX, tx_data);
		if (host_valid === 1'b1 && host_ready === 1'b1) cmp("host_data", qh.size() ? qh.pop_front() : 8'hXX, host_data);
		if (link_err === 1'b1) n_link++;
	end
	// frame builder: header, n random payload bytes, noted for the host if delivered
	task automatic mk(input logic [7:0] id, input logic [7:0] code, input int len, input int n, input logic dlv);
		logic [7:0] b;
		f = '{id, ZERO_BYTE, code, AREA_BLOCK};
		if (id != ID_CONT) f = {f, 8'h0A, 8'h01, 8'(len >> 8), 8'(len), 8'hFF, 8'hFF};
		for (int i = 0; i < n; i++) begin
			b = 8'($urandom);
			f.push_back(b);
			if (dlv) qh.push_back(b);
		end
	endtask : mk
	task automatic exp_resp(input logic [7:0] id, input logic [7:0] e);
		logic [7:0] r[6];
		logic [7:0] x;
		r = '{id, ZERO_BYTE, ZERO_BYTE, e, DLE_BYTE, ETX_BYTE};
		x = BCC_INIT;
		foreach (r[i]) begin
			qt.push_back(r[i]);
			x = x ^ r[i];
		end
		if (bcc_en) qt.push_back(x);
	endtask : exp_resp
	task automatic settle(input int k);
		int n;
		n = 0;
		while ((qt.size() != 0 || qh.size() != 0) && n < 3000) begin
			@(negedge core_clk);
			n++;
		end
		repeat (30) @(negedge core_clk);
		cmp("pending", 8'h00, 8'(qt.size() + qh.size()));
		$display("test %0d done", k);
	endtask : settle
	initial begin
		#400000;
		n_fail++;
		finish_test();
	end
	initial begin
		void'($urandom(23007));
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		cmp("rx_ready", 8'h00, {7'h00, rx_ready});
		sys_rst <= 1'b0;
		repeat (3) @(negedge core_clk);
		mk(ID_FIRST, CODE_WRITE, 5, 5, 1'b1);
		exp_resp(ID_FIRST, ERR_NONE);
		u_srw_partner.send_frame(f, 1'b0, 1'b0);
		settle(1);
		cmp("data_block_number", 8'h0A, dbn);
		cmp("data_word_number", 8'h01, dwn);
		bcc_en <= 1'b1;
		slow <= 1'b1;
		@(negedge core_clk);
		mk(ID_FIRST, CODE_WRITE, 200, 128, 1'b1);
		exp_resp(ID_FIRST, ERR_NONE);
		u_srw_partner.send_frame(f, 1'b0, 1'b0);
		settle(2);
		slow <= 1'b0;
		mk(ID_CONT, CODE_WRITE, 0, 72, 1'b1);
		exp_resp(ID_CONT, ERR_NONE);
		u_srw_partner.send_frame(f, 1'b0, 1'b0);
		settle(3);
		mk(ID_FIRST, CODE_WRITE, 5, 3, 1'b1);
		exp_resp(ID_FIRST, ERR_LEN);
		u_srw_partner.send_frame(f, 1'b0, 1'b0);
		settle(4);
		cmp("resp_err", ERR_LEN, resp_err);
		mk(ID_FIRST, CODE_WRITE, 200, 130, 1'b1);
		void'(qh.pop_back());
		void'(qh.pop_back());
		exp_resp(ID_FIRST, ERR_LEN);
		u_srw_partner.send_frame(f, 1'b0, 1'b0);
		settle(5);
		mk(ID_FIRST, 8'h42, 2, 2, 1'b0);
		exp_resp(ID_FIRST, ERR_HDR);
		u_srw_partner.send_frame(f, 1'b0, 1'b0);
		settle(6);
		cmp("resp_err", ERR_HDR, resp_err);
		mk(ID_CONT, CODE_WRITE, 0, 2, 1'b0);
		exp_resp(ID_CONT, ERR_SEQ);
		u_srw_partner.send_frame(f, 1'b0, 1'b0);
		settle(7);
		cmp("resp_err", ERR_SEQ, resp_err);
		mk(ID_FIRST, CODE_WRITE, 0, 0, 1'b0);
		f = f[0:2];
		u_srw_partner.send_frame(f, 1'b0, 1'b1);
		settle(8);
		mk(ID_FIRST, CODE_WRITE, 0, 0, 1'b0);
		u_srw_partner.send_frame(f, 1'b1, 1'b0);
		settle(9);
		cmp("link_err", 8'h02, 8'(n_link));
		finish_test();
	end
endmodule : srw_frame_rx_tb
`default_nettype wire
